// ---- fps_core_end.sv ----
`timescale 1ns/1ps
module fps_core_end
  import fps_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        srst,
  fps_sfr_if.core          sfr,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        download_mode,
  input  wire logic        wdt_lock,
  input  wire logic        irq_req,
  output logic             irq_taken
);

  fps_host_state_t hstate, next_hstate;
  logic [7:0]  iss_addr, next_iss_addr;
  logic [7:0]  iss_data, next_iss_data;
  logic        iss_wr, next_iss_wr;
  logic [7:0]  r0, next_r0;
  logic [7:0]  rdbuf, next_rdbuf;
  logic        refused, next_refused;
  logic [31:0] ticks;
  logic        access;
  logic        ctrl_wr;
  logic [7:0]  op;
  logic [7:0]  fdata;
  logic [7:0]  faddr;

  assign access    = psel & penable;
  assign ctrl_wr   = access & pwrite & (paddr == REG_CTRL);
  assign op        = pwdata[CTRL_OP_LSB +: 8];
  assign fdata     = pwdata[CTRL_DATA_LSB +: 8];
  assign faddr     = pwdata[CTRL_ADDR_LSB +: 8];
  assign pready    = 1'b1;
  assign sfr.addr  = iss_addr;
  assign sfr.wdata = iss_data;
  assign sfr.wr    = (hstate == HOST_ISSUE) & iss_wr;
  assign sfr.rd    = (hstate == HOST_ISSUE) & ~iss_wr;
  // Interrupts held off while the core is stalled
  assign irq_taken = irq_req & (hstate == HOST_IDLE) & ~sfr.busy;
  assign pslverr   = access & ((pwrite & (paddr != REG_CTRL)) | (ctrl_wr & (hstate != HOST_IDLE))
                     | (!pwrite & paddr != REG_STATUS & paddr != REG_TICKS & paddr != REG_CTRL));

  always_comb begin
    case (paddr)
      REG_CTRL:   prdata = {8'h00, 8'h00, iss_addr, iss_data};
      REG_STATUS: prdata = {8'h00, r0, rdbuf, 3'b000, wdt_lock, download_mode, refused, sfr.busy,
                            hstate != HOST_IDLE};
      REG_TICKS:  prdata = ticks;
      default:    prdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    next_hstate   = hstate;
    next_iss_addr = iss_addr;
    next_iss_data = iss_data;
    next_iss_wr   = iss_wr;
    next_r0       = r0;
    next_rdbuf    = rdbuf;
    next_refused  = refused;
    case (hstate)
      HOST_IDLE: begin
        if (ctrl_wr && !sfr.busy) begin
          next_refused = 1'b0;
          case (op)
            HOST_SFR_WRITE, HOST_SFR_READ: begin
              next_iss_addr = faddr;
              next_iss_data = fdata;
              next_iss_wr   = (op == HOST_SFR_WRITE);
              next_hstate   = HOST_ISSUE;
            end
            EMU_LOAD_R0: begin
              if (download_mode) begin
                next_r0 = fdata;
              end else begin
                next_refused = 1'b1;
              end
            end
            EMU_STORE_R0: begin
              if (download_mode) begin
                next_iss_addr = fdata;
                next_iss_data = r0;
                next_iss_wr   = 1'b1;
                next_hstate   = HOST_ISSUE;
              end else begin
                next_refused = 1'b1;
              end
            end
            default: next_refused = 1'b1;
          endcase
        end
      end
      HOST_ISSUE: next_hstate = HOST_SETTLE;
      HOST_SETTLE: begin
        if (!iss_wr) begin
          next_rdbuf = sfr.rdata;
        end
        if (sfr.refused) begin
          next_refused = 1'b1;
        end
        next_hstate = HOST_WAIT;
      end
      HOST_WAIT: begin
        if (!sfr.busy) begin
          next_hstate = HOST_IDLE;
        end
      end
      default: next_hstate = HOST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hstate   <= HOST_IDLE;
      iss_addr <= RST_PTR;
      iss_data <= RST_DATA;
      iss_wr   <= 1'b0;
      r0       <= RST_DATA;
      rdbuf    <= RST_DATA;
      refused  <= 1'b0;
      ticks    <= 32'h0000_0000;
    end else begin
      hstate   <= next_hstate;
      iss_addr <= next_iss_addr;
      iss_data <= next_iss_data;
      iss_wr   <= next_iss_wr;
      r0       <= next_r0;
      rdbuf    <= next_rdbuf;
      refused  <= next_refused;
      ticks    <= ticks + 32'h0000_0001;
    end
  end

endmodule : fps_core_end

// ---- fps_flash_end.sv ----
`timescale 1ns/1ps
module fps_flash_end
  import fps_pkg::*;
#(
  parameter int unsigned PAGE_ERASE_CYC  = PAGE_ERASE_CYCLES,
  parameter int unsigned ERASE_ALL_CYC   = ERASE_ALL_CYCLES,
  parameter int unsigned ERASE_WRITE_CYC = ERASE_WRITE_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic srst,
  fps_sfr_if.flash  sfr,
  input  wire logic download_enable_n,
  output logic      download_mode,
  output logic      wdt_lock,
  output logic      prot_active
);

  function automatic logic is_guard_addr(input logic [ADDR_W-1:0] a);
    return a >= GUARD_BASE_ADDR;
  endfunction : is_guard_addr
  // Array and stored guards power up erased
  logic [7:0]        mem [FLASH_BYTES] = '{default: ERASED_BYTE};
  logic [7:0]        nv_key = ERASED_BYTE, next_nv_key;
  logic [7:0]        nv_rp = ERASED_BYTE, next_nv_rp;
  logic [31:0]       nv_wp = '1, next_nv_wp;
  fps_dev_state_t    state, next_state;
  logic [7:0]        cmd, next_cmd, edata, next_edata, rdata, next_rdata;
  logic [7:0]        ptr_h, next_ptr_h, ptr_l, next_ptr_l;
  logic [7:0]        wp_up, next_wp_up, wp_lo, next_wp_lo;
  logic [7:0]        rguard, next_rguard, gkey, next_gkey;
  logic              key_ok, next_key_ok, refused, next_refused;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic [ADDR_W-1:0] er_ptr, next_er_ptr, mem_addr, ptr;
  logic [ADDR_W:0]   er_left, next_er_left;
  logic [31:0]       act_wp;
  logic [7:0]        act_rp, act_key, mem_wdata, guard_byte;
  logic [4:0]        page;
  logic              dl_s1, dl_s2, mem_we, scheme, wp_hit, rp_hit, key_match;

  assign ptr  = {ptr_h[5:0], ptr_l};
  assign page = ptr[13:9];
  assign scheme = ~act_wp[PAGES-1];
  assign wp_hit = scheme & ~act_wp[page];
  assign rp_hit = scheme & ~act_rp[page[4:2]] & ~is_guard_addr(ptr);
  assign key_match = (nv_key == ERASED_BYTE) | (gkey == nv_key);
  assign prot_active = scheme;
  assign wdt_lock = ~act_key[7];
  assign sfr.busy    = (state == FPS_RUN);
  assign sfr.refused = refused;
  assign sfr.rdata   = rdata;
  always_comb begin
    case (ptr[2:0])
      3'd2:    guard_byte = nv_key;
      3'd3:    guard_byte = nv_rp;
      3'd4:    guard_byte = nv_wp[7:0];
      3'd5:    guard_byte = nv_wp[15:8];
      3'd6:    guard_byte = nv_wp[23:16];
      default: guard_byte = nv_wp[31:24];
    endcase
  end
  always_comb begin
    next_state   = state;
    next_cmd     = cmd;
    next_ptr_h   = ptr_h;
    next_ptr_l   = ptr_l;
    next_wp_up   = wp_up;
    next_wp_lo   = wp_lo;
    next_rguard  = rguard;
    next_gkey    = gkey;
    next_edata   = edata;
    next_key_ok  = key_ok;
    next_cnt     = cnt;
    next_er_ptr  = er_ptr;
    next_er_left = er_left;
    next_refused = 1'b0;
    next_nv_key  = nv_key;
    next_nv_rp   = nv_rp;
    next_nv_wp   = nv_wp;
    mem_we       = 1'b0;
    mem_addr     = ptr;
    mem_wdata    = edata;
    next_rdata   = rdata;
    if (sfr.rd) begin
      case (sfr.addr)
        SFR_CMD:        next_rdata = cmd;
        SFR_DATA:       next_rdata = edata;
        SFR_READ_GUARD: next_rdata = rguard;
        SFR_WP_LOWER:   next_rdata = wp_lo;
        SFR_WP_UPPER:   next_rdata = wp_up;
        SFR_PTR_LOW:    next_rdata = ptr_l;
        SFR_PTR_HIGH:   next_rdata = ptr_h;
        default:        next_rdata = 8'h00;
      endcase
    end
    case (state)
      FPS_IDLE: begin
        if (sfr.wr) begin
          case (sfr.addr)
            SFR_CMD: begin
              next_cmd    = sfr.wdata;
              next_key_ok = 1'b0;
              next_refused = 1'b1;
              if (key_ok) begin
                case (sfr.wdata)
                  CMD_WRITE: if (!wp_hit && !is_guard_addr(ptr)) begin
                    next_refused = 1'b0;
                    next_cnt     = CNT_W'(WRITE_CYCLES - 1);
                  end
                  CMD_ERASE_PAGE, CMD_ERASE_WRITE: if (!wp_hit && !(sfr.wdata == CMD_ERASE_WRITE
                                                        && is_guard_addr(ptr))) begin
                    next_refused = 1'b0;
                    next_er_ptr  = {page, 9'h000};
                    next_er_left = (ADDR_W+1)'(PAGE_BYTES);
                    next_cnt     = (sfr.wdata == CMD_ERASE_PAGE) ? CNT_W'(PAGE_ERASE_CYC - 1)
                                                                 : CNT_W'(ERASE_WRITE_CYC - 1);
                  end
                  CMD_ERASE_ALL: if (key_match) begin
                    next_refused = 1'b0;
                    next_er_ptr  = '0;
                    next_er_left = (ADDR_W+1)'(FLASH_BYTES);
                    next_cnt     = CNT_W'(ERASE_ALL_CYC - 1);
                  end
                  CMD_READ: if (!rp_hit) begin
                    next_refused = 1'b0;
                    next_cnt     = CNT_W'(READ_CYCLES - 1);
                  end
                  CMD_PROTECT: if (key_match) begin
                    next_refused = 1'b0;
                    next_cnt     = CNT_W'(WRITE_CYCLES - 1);
                  end
                  default: next_refused = 1'b1;
                endcase
              end
              if (!next_refused) next_state = FPS_RUN;
            end
            SFR_ACCESS_KEY: next_key_ok = (sfr.wdata == ACCESS_KEY);
            SFR_GUARD_KEY:  next_gkey   = sfr.wdata;
            SFR_DATA:       next_edata  = sfr.wdata;
            SFR_READ_GUARD: next_rguard = sfr.wdata;
            SFR_WP_LOWER:   next_wp_lo  = sfr.wdata;
            SFR_WP_UPPER:   next_wp_up  = sfr.wdata;
            SFR_PTR_LOW:    next_ptr_l  = sfr.wdata;
            SFR_PTR_HIGH:   next_ptr_h  = sfr.wdata;
            default:        next_key_ok = key_ok;
          endcase
        end
      end
      FPS_RUN: begin
        if (er_left != '0) begin
          mem_we       = 1'b1;
          mem_addr     = er_ptr;
          mem_wdata    = ERASED_BYTE;
          next_er_ptr  = er_ptr + 1'b1;
          next_er_left = er_left - 1'b1;
        end
        if (cnt != '0) next_cnt = cnt - 1'b1;
        if (cnt == '0 && er_left == '0) begin
          next_state = FPS_IDLE;
          case (cmd)
            CMD_WRITE, CMD_ERASE_WRITE: mem_we = 1'b1;
            CMD_READ:      next_edata = is_guard_addr(ptr) ? guard_byte : mem[ptr];
            CMD_ERASE_ALL: begin
              next_nv_key = ERASED_BYTE;
              next_nv_rp  = ERASED_BYTE;
              next_nv_wp  = '1;
            end
            CMD_PROTECT: begin
              next_nv_wp = nv_wp & {ptr_h, ptr_l, wp_up, wp_lo};
              next_nv_rp = nv_rp & rguard;
              next_nv_key = (nv_key == ERASED_BYTE) ? gkey : nv_key;
            end
            default: next_nv_key = nv_key;
          endcase
        end
      end
      default: next_state = FPS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    nv_key <= next_nv_key;
    nv_rp  <= next_nv_rp;
    nv_wp  <= next_nv_wp;
    dl_s1  <= download_enable_n;
    dl_s2  <= dl_s1;
  end
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state   <= FPS_IDLE;
      cmd     <= RST_CMD;
      ptr_h   <= RST_PTR;
      ptr_l   <= RST_PTR;
      wp_up   <= RST_GUARD;
      wp_lo   <= RST_GUARD;
      rguard  <= RST_GUARD;
      gkey    <= RST_GUARD;
      edata   <= RST_DATA;
      key_ok  <= 1'b0;
      cnt     <= '0;
      er_ptr  <= '0;
      er_left <= '0;
      refused <= 1'b0;
      rdata   <= RST_DATA;
      act_wp  <= nv_wp;
      act_rp  <= nv_rp;
      act_key <= nv_key;
      download_mode <= ~dl_s2;
    end else begin
      state   <= next_state;
      cmd     <= next_cmd;
      ptr_h   <= next_ptr_h;
      ptr_l   <= next_ptr_l;
      wp_up   <= next_wp_up;
      wp_lo   <= next_wp_lo;
      rguard  <= next_rguard;
      gkey    <= next_gkey;
      edata   <= next_edata;
      key_ok  <= next_key_ok;
      cnt     <= next_cnt;
      er_ptr  <= next_er_ptr;
      er_left <= next_er_left;
      refused <= next_refused;
      rdata   <= next_rdata;
    end
  end

endmodule : fps_flash_end

// ---- fps_pkg.sv ----
package fps_pkg;
  // Clock and flash geometry
  localparam int unsigned CLK_MHZ     = 40;
  localparam int unsigned FLASH_BYTES = 16384;
  localparam int unsigned PAGE_BYTES  = 512;
  localparam int unsigned PAGES       = 32;
  localparam int unsigned ADDR_W      = 14;
  localparam int unsigned CNT_W       = 24;

  // Special function register addresses
  localparam logic [7:0] SFR_CMD        = 8'hb9;
  localparam logic [7:0] SFR_ACCESS_KEY = 8'hba;
  localparam logic [7:0] SFR_GUARD_KEY  = 8'hbb;
  localparam logic [7:0] SFR_DATA       = 8'hbc;
  localparam logic [7:0] SFR_READ_GUARD = 8'hbf;
  localparam logic [7:0] SFR_WP_LOWER   = 8'hc1;
  localparam logic [7:0] SFR_WP_UPPER   = 8'hc2;
  localparam logic [7:0] SFR_PTR_LOW    = 8'hc6;
  localparam logic [7:0] SFR_PTR_HIGH   = 8'hc7;

  // Flash commands and keys
  localparam logic [7:0] CMD_WRITE       = 8'h01;
  localparam logic [7:0] CMD_ERASE_PAGE  = 8'h02;
  localparam logic [7:0] CMD_ERASE_ALL   = 8'h03;
  localparam logic [7:0] CMD_READ        = 8'h04;
  localparam logic [7:0] CMD_ERASE_WRITE = 8'h05;
  localparam logic [7:0] CMD_PROTECT     = 8'h08;
  localparam logic [7:0] ACCESS_KEY      = 8'h3b;
  localparam logic [7:0] ERASED_BYTE     = 8'hff;

  // Protection bytes at the top of the last page
  localparam logic [ADDR_W-1:0] GUARD_BASE_ADDR = 14'h3ffa;

  // Reset values
  localparam logic [7:0] RST_CMD   = 8'h00;
  localparam logic [7:0] RST_PTR   = 8'h00;
  localparam logic [7:0] RST_DATA  = 8'h00;
  localparam logic [7:0] RST_GUARD = 8'hff;

  // Operation times and cycle counts
  localparam int unsigned WRITE_TIME_US  = 30;
  localparam int unsigned PAGE_ERASE_MS  = 20;
  localparam int unsigned ERASE_ALL_MS   = 200;
  localparam int unsigned READ_TIME_NS   = 100;
  localparam int unsigned ERASE_WRITE_MS = 21;
  localparam int unsigned WRITE_CYCLES       = WRITE_TIME_US * CLK_MHZ;
  localparam int unsigned READ_CYCLES        = (READ_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned PAGE_ERASE_CYCLES  = PAGE_ERASE_MS * CLK_MHZ * 1000;
  localparam int unsigned ERASE_ALL_CYCLES   = ERASE_ALL_MS * CLK_MHZ * 1000;
  localparam int unsigned ERASE_WRITE_CYCLES = ERASE_WRITE_MS * CLK_MHZ * 1000;

  // Host order codes
  localparam logic [7:0] EMU_LOAD_R0    = 8'h49;
  localparam logic [7:0] EMU_STORE_R0   = 8'h46;
  localparam logic [7:0] HOST_SFR_WRITE = 8'h57;
  localparam logic [7:0] HOST_SFR_READ  = 8'h52;

  // Host APB map and fields
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_STATUS = 12'h004;
  localparam logic [11:0] REG_TICKS  = 12'h008;
  localparam int unsigned CTRL_DATA_LSB   = 0;
  localparam int unsigned CTRL_ADDR_LSB   = 8;
  localparam int unsigned CTRL_OP_LSB     = 16;
  localparam int unsigned ST_PENDING_BIT  = 0;
  localparam int unsigned ST_BUSY_BIT     = 1;
  localparam int unsigned ST_REFUSED_BIT  = 2;
  localparam int unsigned ST_DL_BIT       = 3;
  localparam int unsigned ST_WDT_BIT      = 4;
  localparam int unsigned ST_RDATA_LSB    = 8;
  localparam int unsigned ST_R0_LSB       = 16;

  typedef enum logic [0:0] {FPS_IDLE, FPS_RUN} fps_dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_ISSUE, HOST_SETTLE, HOST_WAIT} fps_host_state_t;
endpackage : fps_pkg

// ---- fps_props.sv ----
`timescale 1ns/1ps
module fps_props
  import fps_pkg::*;
#(
  parameter int unsigned PAGE_ERASE_CYC  = PAGE_ERASE_CYCLES,
  parameter int unsigned ERASE_ALL_CYC   = ERASE_ALL_CYCLES,
  parameter int unsigned ERASE_WRITE_CYC = ERASE_WRITE_CYCLES
) (
  input wire logic       ref_clk,
  input wire logic       srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       busy,
  input wire logic       refused,
  input wire logic       irq_taken,
  input wire logic       prot_active,
  input wire logic       wdt_lock
);
  logic [CNT_W-1:0] busy_cnt;
  logic [CNT_W-1:0] next_busy_cnt;
  logic             cmd_wr;

  assign cmd_wr = wr && addr == SFR_CMD && !busy;

  // Length of the current busy stretch
  always_comb begin
    next_busy_cnt = busy ? busy_cnt + 1'b1 : '0;
  end

  always_ff @(posedge ref_clk) begin
    busy_cnt <= srst ? '0 : next_busy_cnt;
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_cmd_answer: assert property (cmd_wr |=> busy ^ refused)
    else $error("command write got neither busy nor refusal");
  a_refuse_cause: assert property (refused |-> $past(cmd_wr))
    else $error("refusal without a command write");
  a_refuse_pulse: assert property (refused |=> !refused)
    else $error("refusal longer than one cycle");
  a_read_length: assert property (cmd_wr && wdata == CMD_READ ##1 busy |-> busy[*4] ##1 !busy)
    else $error("read busy not four cycles");
  a_op_length: assert property ($fell(busy) |->
      busy_cnt inside {READ_CYCLES, WRITE_CYCLES, PAGE_ERASE_CYC, ERASE_WRITE_CYC, ERASE_ALL_CYC})
    else $error("busy stretch of unexpected length");
  a_busy_hold: assert property ($rose(busy) |-> busy[*4])
    else $error("busy dropped early");
  a_irq_stall: assert property (busy |-> !irq_taken)
    else $error("interrupt taken while flash busy");
  a_prot_frozen: assert property (!$past(srst) |-> $stable(prot_active) && $stable(wdt_lock))
    else $error("active protection changed outside reset");

  c_busy: cover property ($rose(busy));
  c_refused: cover property (refused);
  c_irq: cover property (irq_taken ##1 busy);
endmodule : fps_props

// ---- fps_sfr_if.sv ----
`timescale 1ns/1ps
interface fps_sfr_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       busy;
  logic       refused;
  modport core  (output addr, output wdata, output wr, output rd, input rdata, input busy, input refused);
  modport flash (input addr, input wdata, input wr, input rd, output rdata, output busy, output refused);
endinterface : fps_sfr_if

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import fps_pkg::*;
  localparam int unsigned PE = 600, EA = 20000, EW = 600, LIMIT = 90000;
  logic        ref_clk, srst, download_enable_n, psel, penable, pwrite, chk, irq_req;
  logic        pready, pslverr, download_mode, wdt_lock, prot_active, irq_taken;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [32:0] exp_q[$], mask_q[$];
  logic [7:0]  v;
  int          n_errors, check_count, cycles;

  fps_sfr_if i_fps_sfr_if ();
  fps_flash_end #(.PAGE_ERASE_CYC(PE), .ERASE_ALL_CYC(EA), .ERASE_WRITE_CYC(EW)) i_fps_flash_end (
    .ref_clk(ref_clk), .srst(srst), .sfr(i_fps_sfr_if), .download_enable_n(download_enable_n),
    .download_mode(download_mode), .wdt_lock(wdt_lock), .prot_active(prot_active));
  fps_core_end i_fps_core_end (.ref_clk(ref_clk), .srst(srst), .sfr(i_fps_sfr_if), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .download_mode(download_mode), .wdt_lock(wdt_lock), .irq_req(irq_req),
    .irq_taken(irq_taken));
  fps_props #(.PAGE_ERASE_CYC(PE), .ERASE_ALL_CYC(EA), .ERASE_WRITE_CYC(EW)) i_fps_props (
    .ref_clk(ref_clk), .srst(srst), .addr(i_fps_sfr_if.addr), .wdata(i_fps_sfr_if.wdata),
    .wr(i_fps_sfr_if.wr), .busy(i_fps_sfr_if.busy), .refused(i_fps_sfr_if.refused),
    .irq_taken(irq_taken), .prot_active(prot_active), .wdt_lock(wdt_lock));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Read capture, result compare and hang guard
  always @(posedge ref_clk) begin
    irq_req <= 1'($urandom);
    cycles <= cycles + 1;
    if (psel && penable && pready) rd_q <= prdata;
    if (psel && penable && pready && !pwrite && chk && exp_q.size() > 0) begin
      check_count++;
      if (({pslverr, prdata} & mask_q[0]) !== exp_q[0]) begin
        $display("wrong value at %0t: got %h want %h", $time, {pslverr, prdata} & mask_q[0], exp_q[0]);
        n_errors++;
      end
      void'(exp_q.pop_front());
      void'(mask_q.pop_front());
    end
    if (cycles == LIMIT) begin
      $display("wrong value at %0t: run did not finish", $time);
      n_errors++;
      print_verdict();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic c);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
    @(negedge ref_clk);
  endtask : apb

  task sfr(input logic [7:0] op, input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, REG_CTRL, {8'h00, op, a, d}, 1'b0);
    do apb(1'b0, REG_STATUS, 32'h0, 1'b0);
    while (rd_q[ST_PENDING_BIT] !== 1'b0 || rd_q[ST_BUSY_BIT] !== 1'b0);
  endtask : sfr

  task chk_reg(input logic [11:0] a, input logic [32:0] m, input logic [32:0] e);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    apb(1'b0, a, 32'h0, 1'b1);
  endtask : chk_reg

  task fcmd(input logic [13:0] a, input logic [7:0] d, input logic [7:0] c, input logic k);
    sfr(HOST_SFR_WRITE, SFR_PTR_HIGH, {2'b00, a[13:8]});
    sfr(HOST_SFR_WRITE, SFR_PTR_LOW, a[7:0]);
    sfr(HOST_SFR_WRITE, SFR_DATA, d);
    if (k) sfr(HOST_SFR_WRITE, SFR_ACCESS_KEY, ACCESS_KEY);
    sfr(HOST_SFR_WRITE, SFR_CMD, c);
  endtask : fcmd

  task rb(input logic [13:0] a, input logic [7:0] e);
    fcmd(a, 8'h00, CMD_READ, 1'b1);
    sfr(HOST_SFR_READ, SFR_DATA, 8'h00);
    chk_reg(REG_STATUS, 33'h0ff00, {17'h0, e, 8'h00});
  endtask : rb

  task prot(input logic [7:0] lo, up, pl, ph, rg, key);
    sfr(HOST_SFR_WRITE, SFR_WP_LOWER, lo);
    sfr(HOST_SFR_WRITE, SFR_WP_UPPER, up);
    sfr(HOST_SFR_WRITE, SFR_PTR_LOW, pl);
    sfr(HOST_SFR_WRITE, SFR_PTR_HIGH, ph);
    sfr(HOST_SFR_WRITE, SFR_READ_GUARD, rg);
    sfr(HOST_SFR_WRITE, SFR_GUARD_KEY, key);
    sfr(HOST_SFR_WRITE, SFR_ACCESS_KEY, ACCESS_KEY);
    sfr(HOST_SFR_WRITE, SFR_CMD, CMD_PROTECT);
  endtask : prot

  task rst(input logic strap);
    @(posedge ref_clk);
    download_enable_n <= strap;
    srst <= 1'b1;
    repeat (16) @(posedge ref_clk);
    srst <= 1'b0;
  endtask : rst

  task print_verdict;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    void'($urandom(63819));
    {psel, penable, pwrite, chk, irq_req, paddr, pwdata} = '0;
    {n_errors, check_count, cycles} = '0;
    srst = 1'b1;
    download_enable_n = 1'b0;
    rst(1'b0);
    chk_reg(REG_STATUS, 33'h8, 33'h8);
    // Back-to-back reads are three clocks apart
    apb(1'b0, REG_TICKS, 32'h0, 1'b0);
    chk_reg(REG_TICKS, 33'h1_ffff_ffff, {1'b0, rd_q + 32'h0000_0003});
    chk_reg(12'h00c, 33'h1_0000_0000, 33'h1_0000_0000);
    v = 8'($urandom);
    sfr(EMU_LOAD_R0, 8'h00, v);
    sfr(EMU_STORE_R0, 8'h00, SFR_DATA);
    sfr(HOST_SFR_READ, SFR_DATA, 8'h00);
    chk_reg(REG_STATUS, 33'hffff00, {9'h0, v, v, 8'h00});
    sfr(8'h99, 8'h00, 8'h00);
    chk_reg(REG_STATUS, 33'h4, 33'h4);
    fcmd(14'h0100, v, CMD_WRITE, 1'b0);
    rb(14'h0100, 8'hff);
    fcmd(14'h0100, v, CMD_WRITE, 1'b1);
    rb(14'h0100, v);
    fcmd(14'h3800, 8'h99, CMD_WRITE, 1'b1);
    fcmd(14'h0201, 8'h33, CMD_WRITE, 1'b1);
    prot(8'hfe, 8'hff, 8'hff, 8'h7f, 8'h7f, 8'h23);
    fcmd(14'h0000, 8'h5a, CMD_WRITE, 1'b1);
    rb(14'h0000, 8'h5a);
    chk_reg(REG_STATUS, 33'h10, 33'h0);
    rst(1'b1);
    chk_reg(REG_STATUS, 33'h18, 33'h10);
    fcmd(14'h0001, 8'h11, CMD_WRITE, 1'b1);
    rb(14'h0001, 8'hff);
    fcmd(14'h0200, 8'h44, CMD_ERASE_WRITE, 1'b1);
    rb(14'h0201, 8'hff);
    rb(14'h0200, 8'h44);
    fcmd(14'h0200, 8'h00, CMD_ERASE_PAGE, 1'b1);
    rb(14'h0200, 8'hff);
    rb(14'h3ffc, 8'hfe);
    rb(14'h3fff, 8'h7f);
    rb(14'h3ffa, 8'h23);
    rb(14'h3800, 8'h00);
    rb(14'h37ff, 8'hff);
    prot(8'hff, 8'hff, 8'hff, 8'h00, 8'hff, 8'h11);
    prot(8'hff, 8'hff, 8'hff, 8'h3f, 8'hff, 8'h23);
    rst(1'b1);
    rb(14'h3fff, 8'h3f);
    rb(14'h3ffb, 8'h7f);
    rb(14'h3ffa, 8'h23);
    sfr(HOST_SFR_WRITE, SFR_GUARD_KEY, 8'h23);
    fcmd(14'h0000, 8'h00, CMD_ERASE_ALL, 1'b1);
    rst(1'b1);
    rb(14'h3ffb, 8'hff);
    rb(14'h0100, 8'hff);
    chk_reg(REG_STATUS, 33'h10, 33'h0);
    print_verdict();
  end
endmodule : tb
